/* File: hw/spi_fifo.sv */
// small valid/ready fifo holding received bytes
// assumes one clock, synchronous active-low reset
`timescale 1ns/10ps
module spi_fifo #(
  parameter int WIDTH = 8,
  parameter int DEPTH = 4
) (
  input  wire logic             clk,
  input  wire logic             rst_n,
  input  wire logic [WIDTH-1:0] inData,
  input  wire logic             inValid,
  output logic                  inReady,
  output logic      [WIDTH-1:0] outData,
  output logic                  outValid,
  input  wire logic             outReady
);
  localparam int AW = $clog2(DEPTH);
  if (DEPTH < 2 || (1 << AW) != DEPTH) begin : gDepthCheck
    $error("fifo depth must be a power of two");
  end
  logic [WIDTH-1:0] mem [DEPTH];
  logic [AW:0]      wrPtr_r;
  logic [AW:0]      rdPtr_r;
  wire              doWr = inValid && inReady;
  wire              doRd = outValid && outReady;
  assign inReady  = (wrPtr_r - rdPtr_r) != (AW+1)'(DEPTH);
  assign outValid = wrPtr_r != rdPtr_r;
  assign outData  = mem[rdPtr_r[AW-1:0]];
  always_ff @(posedge clk) begin
    if (doWr) begin
      mem[wrPtr_r[AW-1:0]] <= inData;
    end
  end
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      wrPtr_r <= '0;
      rdPtr_r <= '0;
    end else begin
      wrPtr_r <= wrPtr_r + (AW+1)'(doWr);
      rdPtr_r <= rdPtr_r + (AW+1)'(doRd);
    end
  end
endmodule

/* File: hw/spi_port.sv */
// serial peripheral port: master engine on clk, slave shifter on the link clock
// assumes pins are resolved outside from the enables; link clock stops between frames
`timescale 1ns/10ps
module spi_port #(
  parameter int DEPTH = 4
) (
  input  wire logic       clk,
  input  wire logic       rst_n,
  input  wire logic       linkClk,
  input  wire logic       portEnable,
  input  wire logic       masterEnable,
  input  wire logic       enableLoad,
  input  wire logic [1:0] selectMode,
  input  wire logic       clockPolarity,
  input  wire logic       clockPhase,
  input  wire logic [7:0] clockRate,
  input  wire logic [7:0] writeData,
  input  wire logic       writeStrobe,
  output logic            writeReady,
  output logic [7:0]      readData,
  output logic            readValid,
  input  wire logic       readStrobe,
  input  wire logic       flagClear,
  output logic            portEnabled,
  output logic            masterEnabled,
  output logic            transferComplete,
  output logic            modeFault,
  output logic            busy,
  output logic            masterOut,
  output logic            masterOutEn,
  input  wire logic       masterOutIn,
  output logic            masterInOut,
  output logic            masterInEn,
  input  wire logic       masterInIn,
  output logic            serialClkOut,
  output logic            serialClkEn,
  output logic            selectOut,
  output logic            selectEn,
  input  wire logic       selectIn,
  output logic            selectRouted
);
  if (DEPTH != 4 && DEPTH != 8) begin : gDepthCheck
    $error("depth must be 4 or 8");
  end

  // enable bits: software load, cleared by fault until reloaded
  logic portEn_r, master_enable_bit_r, fault_r, done_r;
  logic [2:0] selSync_r;
  logic [2:0] misoSync_r;
  wire  selLow   = !selSync_r[1];
  wire  selFall  = selSync_r[2] && !selSync_r[1];
  wire  multiMst = selectMode == spi_port_pkg::SEL_FOUR_IN;
  wire  isMaster = portEn_r && master_enable_bit_r;
  wire  faultEv  = isMaster && multiMst && selFall;
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      selSync_r  <= 3'h7;
      misoSync_r <= 3'h0;
    end else begin
      selSync_r  <= {selSync_r[1:0], selectIn};
      misoSync_r <= {misoSync_r[1:0], masterInIn};
    end
  end
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      portEn_r <= 1'b0;
      master_enable_bit_r  <= 1'b0;
      fault_r  <= 1'b0;
    end else if (faultEv) begin
      portEn_r <= 1'b0;
      master_enable_bit_r  <= 1'b0;
      fault_r  <= 1'b1;
    end else begin
      if (enableLoad) begin
        portEn_r <= portEnable;
        master_enable_bit_r  <= masterEnable;
      end
      if (flagClear) fault_r <= 1'b0;
    end
  end

  // master engine
  spi_port_pkg::mstate_e st_r;
  logic [7:0] txBuf_r, shift_r;
  logic       txFull_r;
  logic [3:0] bitCnt_r;
  logic [8:0] divCnt_r;
  logic       sckInt_r;
  logic       rxBit_r;
  wire  [8:0] halfPer = (9'(clockRate) + 9'h1 < 9'(spi_port_pkg::MIN_HALF_CYCLES))
                        ? 9'(spi_port_pkg::MIN_HALF_CYCLES) : 9'(clockRate) + 9'h1;
  wire        tick    = divCnt_r + 9'h1 >= halfPer;
  wire        start   = isMaster && st_r == spi_port_pkg::IDLE && txFull_r;
  wire        lastBit = bitCnt_r == 4'(spi_port_pkg::BYTE_BITS - 1);
  wire        endXfer = st_r == spi_port_pkg::TRAIL && tick && lastBit;
  wire        sampleIn = misoSync_r[1];
  wire        rxReady;
  // sample and shift edges swap with phase; a separate sample bit keeps
  // the outgoing msb intact until it has been sent
  wire        leadTick  = st_r == spi_port_pkg::LEAD && tick;
  wire        trailTick = st_r == spi_port_pkg::TRAIL && tick;
  wire        sampleNow = clockPhase ? trailTick : leadTick;
  wire        shiftNow  = clockPhase ? leadTick && bitCnt_r != 4'h0
                                     : trailTick && !lastBit;
  assign writeReady = !txFull_r;
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      txBuf_r  <= spi_port_pkg::RESET_BYTE;
      txFull_r <= 1'b0;
    end else begin
      if (writeStrobe && !txFull_r && isMaster) begin
        txBuf_r  <= writeData;
        txFull_r <= 1'b1;
      end else if (start) begin
        txFull_r <= 1'b0;
      end
    end
  end
  always_ff @(posedge clk) begin
    if (!rst_n || !isMaster) begin
      st_r     <= spi_port_pkg::IDLE;
      bitCnt_r <= 4'h0;
      divCnt_r <= 9'h0;
      sckInt_r <= 1'b0;
    end else begin
      divCnt_r <= (st_r == spi_port_pkg::IDLE || tick) ? 9'h0 : divCnt_r + 9'h1;
      case (st_r)
        spi_port_pkg::IDLE: begin
          if (start) begin
            bitCnt_r <= 4'h0;
            st_r     <= spi_port_pkg::LEAD;
          end
        end
        spi_port_pkg::LEAD: begin
          if (tick) begin
            sckInt_r <= 1'b1;
            st_r     <= spi_port_pkg::TRAIL;
          end
        end
        spi_port_pkg::TRAIL: begin
          if (tick) begin
            sckInt_r <= 1'b0;
            bitCnt_r <= bitCnt_r + 4'h1;
            st_r     <= lastBit ? spi_port_pkg::IDLE : spi_port_pkg::LEAD;
          end
        end
        default: st_r <= spi_port_pkg::IDLE;
      endcase
    end
  end
  always_ff @(posedge clk) begin
    if (!rst_n || !isMaster) begin
      shift_r <= spi_port_pkg::RESET_BYTE;
    end else if (start) begin
      shift_r <= txBuf_r;
    end else if (shiftNow) begin
      shift_r <= {shift_r[6:0], rxBit_r};
    end
  end
  always_ff @(posedge clk) begin
    if (!rst_n || !isMaster) begin
      rxBit_r <= 1'b0;
    end else if (sampleNow) begin
      rxBit_r <= sampleIn;
    end
  end
  // phase 1 takes its last bit at the closing edge itself
  wire [7:0] rxByte = {shift_r[6:0], clockPhase ? sampleIn : rxBit_r};

  // helper: serial clock toggles within one transfer
  logic [4:0] edgeCnt_r;
  always_ff @(posedge clk) begin
    if (!rst_n || start) edgeCnt_r <= 5'h0;
    else if (leadTick || trailTick) edgeCnt_r <= edgeCnt_r + 5'h1;
  end
  always_ff @(posedge clk) begin
    if (!rst_n) done_r <= 1'b0;
    else if (endXfer) done_r <= 1'b1;
    else if (flagClear) done_r <= 1'b0;
  end
  spi_fifo #(.WIDTH(8), .DEPTH(DEPTH)) rxFifo (
    .clk      (clk),
    .rst_n    (rst_n),
    .inData   (rxByte),
    .inValid  (endXfer),
    .inReady  (rxReady),
    .outData  (readData),
    .outValid (readValid),
    .outReady (readStrobe)
  );

  // slave shifter on link clock; enable and mode are stable during frames
  // tx byte is copied only while the slave is held off, when it cannot move
  logic [1:0] slvEnSync_r;
  logic [7:0] slvShift_r;
  logic [2:0] slvCnt_r;
  wire  slvMode  = portEn_r && !master_enable_bit_r;
  wire  slvSel   = selectMode == spi_port_pkg::SEL_THREE_WIRE || !selectIn;
  always_ff @(posedge linkClk) begin
    slvEnSync_r <= {slvEnSync_r[0], slvMode};
  end
  always_ff @(posedge linkClk) begin
    if (!slvEnSync_r[1]) begin
      slvCnt_r   <= 3'h0;
      slvShift_r <= txBuf_r;
    end else if (slvSel) begin
      slvShift_r <= {slvShift_r[6:0], masterOutIn};
      slvCnt_r   <= slvCnt_r + 3'h1;
    end
  end

  wire threeWire = selectMode == spi_port_pkg::SEL_THREE_WIRE;
  wire drvSel    = selectMode[spi_port_pkg::SEL_HIGH_POS];
  assign masterOut    = shift_r[7];
  assign masterOutEn  = isMaster;
  assign masterInOut  = slvShift_r[7];
  assign masterInEn   = slvMode && (threeWire || (multiMst && selLow));
  assign serialClkOut = sckInt_r ^ clockPolarity;
  assign serialClkEn  = isMaster;
  assign selectOut    = selectMode[spi_port_pkg::SEL_LOW_POS];
  assign selectEn     = portEn_r && drvSel;
  assign selectRouted = !threeWire;
  assign portEnabled      = portEn_r;
  assign masterEnabled    = master_enable_bit_r;
  assign transferComplete = done_r;
  assign modeFault        = fault_r;
  assign busy             = st_r != spi_port_pkg::IDLE;

  // fault and enable handling
  fault_clears_a: assert property (@(posedge clk) disable iff (!rst_n)
    faultEv |=> !portEn_r && !master_enable_bit_r && fault_r) else $error("fault did not disable");
  fault_wins_a: assert property (@(posedge clk) disable iff (!rst_n)
    faultEv && flagClear |=> fault_r) else $error("clear beat fault");
  fault_stays_a: assert property (@(posedge clk) disable iff (!rst_n)
    fault_r && !portEn_r && !enableLoad |=> !portEn_r) else $error("port re-enabled");

  // master transfer
  done_set_a: assert property (@(posedge clk) disable iff (!rst_n)
    endXfer |=> done_r) else $error("complete flag missing");
  done_clear_a: assert property (@(posedge clk) disable iff (!rst_n)
    flagClear && !endXfer |=> !done_r) else $error("complete flag stuck");
  start_load_a: assert property (@(posedge clk) disable iff (!rst_n)
    start |=> busy && shift_r == $past(txBuf_r)) else $error("shift not loaded");
  write_buf_a: assert property (@(posedge clk) disable iff (!rst_n)
    writeStrobe && writeReady && isMaster |=> !writeReady) else $error("write not taken");
  no_write_a: assert property (@(posedge clk) disable iff (!rst_n)
    writeStrobe && !isMaster |=> $stable(txBuf_r)) else $error("write taken as slave");
  rx_push_a: assert property (@(posedge clk) disable iff (!rst_n)
    endXfer && rxReady |=> readValid) else $error("byte not buffered");
  eight_bits_a: assert property (@(posedge clk) disable iff (!rst_n)
    endXfer |-> edgeCnt_r == 5'(2 * spi_port_pkg::BYTE_BITS - 1)) else $error("bit count wrong");
  busy_end_a: assert property (@(posedge clk) disable iff (!rst_n)
    endXfer |=> !busy) else $error("busy after last bit");
  sample_hold_a: assert property (@(posedge clk) disable iff (!rst_n)
    sampleNow |=> $stable(masterOut)) else $error("mosi moved on sampling edge");
  rate_cap_a: assert property (@(posedge clk) disable iff (!rst_n)
    st_r != spi_port_pkg::IDLE && tick |-> divCnt_r >= 9'(spi_port_pkg::MIN_HALF_CYCLES - 1))
    else $error("rate above cap");

  // pins
  miso_release_a: assert property (@(posedge clk) disable iff (!rst_n)
    !portEn_r |-> !masterInEn) else $error("master-in driven while off");
  miso_unsel_a: assert property (@(posedge clk) disable iff (!rst_n)
    slvMode && multiMst && !selLow |-> !masterInEn) else $error("unselected slave drives");
  miso_three_a: assert property (@(posedge clk) disable iff (!rst_n)
    slvMode && threeWire |-> masterInEn) else $error("three-wire slave released");
  mosi_msb_a: assert property (@(posedge clk) disable iff (!rst_n)
    isMaster |-> masterOut == shift_r[7] && masterOutEn) else $error("mosi wrong");
  slave_off_a: assert property (@(posedge clk) disable iff (!rst_n)
    !isMaster |-> !masterOutEn && !serialClkEn) else $error("slave drives master lines");
  clk_idle_a: assert property (@(posedge clk) disable iff (!rst_n)
    !busy |-> serialClkOut == clockPolarity) else $error("idle clock level wrong");
  route_sel_a: assert property (@(posedge clk) disable iff (!rst_n)
    threeWire |-> !selectRouted && !selectEn) else $error("select routed");
  sel_out_a: assert property (@(posedge clk) disable iff (!rst_n)
    portEn_r && drvSel |-> selectEn && selectOut == selectMode[spi_port_pkg::SEL_LOW_POS])
    else $error("select output wrong");

  xfer_cv: cover property (@(posedge clk) disable iff (!rst_n)
    endXfer);
  fault_cv: cover property (@(posedge clk) disable iff (!rst_n)
    faultEv);
  read_cv: cover property (@(posedge clk) disable iff (!rst_n)
    readValid && readStrobe);
  full_cv: cover property (@(posedge clk) disable iff (!rst_n)
    endXfer && !rxReady);
  mode3_cv: cover property (@(posedge clk) disable iff (!rst_n)
    endXfer && clockPhase && clockPolarity);
endmodule

/* File: pkg/spi_port_pkg.sv */
// constants shared by the serial peripheral port
// assumes one system clock domain plus the slave link clock
package spi_port_pkg;
  localparam logic [1:0] SEL_THREE_WIRE = 2'h0;
  localparam logic [1:0] SEL_FOUR_IN    = 2'h1;
  localparam int         SEL_HIGH_POS   = 1;
  localparam int         SEL_LOW_POS    = 0;
  localparam int         BYTE_BITS      = 8;
  localparam int         SYS_CLK_MHZ_X10 = 2000;
  localparam int         MAX_RATE_MHZ_X10 = 125;
  // least half-period in system clocks so that bit rate stays at or under the cap
  localparam int         MIN_HALF_CYCLES =
    (SYS_CLK_MHZ_X10 + 2 * MAX_RATE_MHZ_X10 - 1) / (2 * MAX_RATE_MHZ_X10);
  localparam logic [7:0] RESET_BYTE     = 8'h00;
  localparam logic [7:0] RESET_RATE     = 8'h00;
  typedef enum logic [1:0] {IDLE, LEAD, TRAIL} mstate_e;
endpackage

/* File: test/spi_port_tb.sv */
// self-checking bench for the serial port: master, select modes, fault, slave gating
// assumes pins are resolved here from the enables; link clock runs only in frames
`timescale 1ns/10ps
module spi_port_tb;
  logic clk = 0, rst_n = 0, linkClk = 0, linkRun = 0;
  logic portEnable = 0, masterEnable = 0, enableLoad = 0, clockPolarity = 0, clockPhase = 0;
  logic [1:0] selectMode = 2'h0;
  logic [7:0] clockRate = 8'h00, writeData = 8'h00, slaveTx = 8'h00, clkEdges;
  logic writeStrobe = 0, readStrobe = 0, flagClear = 0, selDrv = 1, mosiDrv = 0, slaveLoad = 0;
  logic writeReady, readValid, portEnabled, masterEnabled, transferComplete, modeFault, busy;
  logic masterOut, masterOutEn, masterInOut, masterInEn, serialClkOut, serialClkEn;
  logic selectOut, selectEn, selectRouted, slaveMiso;
  logic [7:0] readData, slaveRx;
  int mismatches = 0, checkCount = 0;
  wire mosiWire = masterOutEn ? masterOut : mosiDrv;
  wire misoWire = masterInEn ? masterInOut : slaveMiso;
  wire selWire  = selectEn ? selectOut : selDrv;
  always #2.5 clk = ~clk;
  always begin #16; if (linkRun) linkClk = ~linkClk; end
  always @(serialClkOut) clkEdges = clkEdges + 8'h01;
  spi_port #(.DEPTH(4)) spi_port_inst (.clk(clk), .rst_n(rst_n), .linkClk(linkClk),
    .portEnable(portEnable), .masterEnable(masterEnable), .enableLoad(enableLoad),
    .selectMode(selectMode), .clockPolarity(clockPolarity), .clockPhase(clockPhase),
    .clockRate(clockRate), .writeData(writeData), .writeStrobe(writeStrobe),
    .writeReady(writeReady), .readData(readData), .readValid(readValid),
    .readStrobe(readStrobe), .flagClear(flagClear), .portEnabled(portEnabled),
    .masterEnabled(masterEnabled), .transferComplete(transferComplete),
    .modeFault(modeFault), .busy(busy), .masterOut(masterOut), .masterOutEn(masterOutEn),
    .masterOutIn(mosiWire), .masterInOut(masterInOut), .masterInEn(masterInEn),
    .masterInIn(misoWire), .serialClkOut(serialClkOut), .serialClkEn(serialClkEn),
    .selectOut(selectOut), .selectEn(selectEn), .selectIn(selWire),
    .selectRouted(selectRouted));
  spi_slave_model spi_slave_model_inst (.sck(serialClkOut), .cpol(clockPolarity),
    .cpha(clockPhase), .mosi(mosiWire),
    .load(slaveLoad), .txByte(slaveTx), .miso(slaveMiso), .rxByte(slaveRx));
  task automatic check(input string name, input logic [7:0] seen, input logic [7:0] exp);
    checkCount++;
    if (seen !== exp) begin
      mismatches++;
      $display("CHECK FAILED %s expected %h seen %h", name, exp, seen);
    end
  endtask
  task automatic final_report();
    $display("checks %0d mismatches %0d", checkCount, mismatches);
    if (mismatches == 0 && checkCount > 0)
      $display("TB: PASS");
    else
      $display("TB: FAIL");
    $finish;
  endtask
  task automatic setEn(input logic pe, input logic me);
    portEnable = pe;
    masterEnable = me;
    enableLoad = 1;
    @(negedge clk);
    enableLoad = 0;
  endtask
  task automatic pulseClear();
    flagClear = 1;
    @(negedge clk);
    flagClear = 0;
  endtask
  task automatic scnMaster(input logic [7:0] tx, input logic [7:0] rx, input logic pol,
                           input logic pha);
    int i;
    selectMode = 2'h0;
    clockPolarity = pol;
    clockPhase = pha;
    setEn(1, 1);
    // slave loads after the polarity change has settled
    slaveTx = rx;
    slaveLoad = 1;
    clkEdges = 8'h00;
    writeData = tx;
    writeStrobe = 1;
    @(negedge clk);
    writeStrobe = 0;
    slaveLoad = 0;
    for (i = 0; i < 3000 && transferComplete !== 1'b1; i++) @(negedge clk);
    if (i == 3000) begin mismatches++; final_report(); end
    repeat (2) @(negedge clk);
    check("sck edges", clkEdges, 8'h10);
    check("slave got", slaveRx, tx);
    check("read byte", readData, rx);
    check("done flag", {7'h00, transferComplete}, 8'h01);
    check("sel routed", {7'h00, selectRouted}, 8'h00);
    readStrobe = 1;
    pulseClear();
    readStrobe = 0;
  endtask
  task automatic scnSelect();
    selectMode = 2'h3;
    repeat (2) @(negedge clk);
    check("sel out hi", {6'h00, selectEn, selectOut}, 8'h03);
    check("sel routed", {7'h00, selectRouted}, 8'h01);
    selectMode = 2'h2;
    repeat (2) @(negedge clk);
    check("sel out lo", {6'h00, selectEn, selectOut}, 8'h02);
  endtask
  task automatic scnFault();
    int i;
    selectMode = 2'h1;
    selDrv = 1;
    setEn(1, 1);
    repeat (4) @(negedge clk);
    selDrv = 0;
    for (i = 0; i < 20 && modeFault !== 1'b1; i++) @(negedge clk);
    check("fault", {5'h00, modeFault, portEnabled, masterEnabled}, 8'h04);
    selDrv = 1;
    repeat (30) @(negedge clk);
    check("stay off", {6'h00, portEnabled, masterEnabled}, 8'h00);
    pulseClear();
    setEn(1, 1);
    check("re-enabled", {5'h00, modeFault, portEnabled, masterEnabled}, 8'h03);
  endtask
  task automatic scnSlave();
    // unselected slave must neither drive the line nor collect bits
    setEn(0, 0);
    linkRun = 1;
    repeat (100) @(negedge clk);
    setEn(1, 0);
    @(negedge clk);
    check("miso off", {7'h00, masterInEn}, 8'h00);
    repeat (100) @(negedge clk);
    linkRun = 0;
    repeat (4) @(negedge clk);
    check("no byte", {7'h00, readValid}, 8'h00);
    check("held", {7'h00, masterInOut}, 8'h01);
    selectMode = 2'h0;
    linkRun = 1;
    repeat (20) @(negedge clk);
    linkRun = 0;
    repeat (2) @(negedge clk);
    check("miso on", {7'h00, masterInEn}, 8'h01);
    check("shifted", {7'h00, masterInOut}, 8'h00);
    setEn(0, 0);
    @(negedge clk);
    check("disabled", {7'h00, masterInEn}, 8'h00);
  endtask
  initial begin
    repeat (8) @(negedge clk);
    rst_n = 1;
    check("reset", {5'h00, portEnabled, masterEnabled, serialClkOut}, 8'h00);
    scnMaster(8'ha5, 8'h3c, 1'b0, 1'b0);
    scnMaster(8'h5a, 8'hc3, 1'b1, 1'b1);
    scnMaster(8'h81, 8'h7e, 1'b0, 1'b0);
    scnSelect();
    scnFault();
    scnSlave();
    final_report();
  end
endmodule

/* File: test/spi_slave_model.sv */
// far-side slave for the port's master tests, any polarity and phase
// assumes it is the only slave on the bus, so it always answers
`timescale 1ns/10ps
module spi_slave_model (
  input  wire logic       sck,
  input  wire logic       cpol,
  input  wire logic       cpha,
  input  wire logic       mosi,
  input  wire logic       load,
  input  wire logic [7:0] txByte,
  output logic            miso,
  output logic [7:0]      rxByte
);
  logic [7:0] shiftReg;
  logic       first;
  // rises on the leading edge of each bit period whatever the idle level
  wire        leadEdge = sck ^ cpol;
  initial rxByte = 8'h00;
  always @(posedge load) begin
    shiftReg = txByte;
    first = 1'b1;
  end
  // phase 0 samples on the leading edge, phase 1 on the trailing edge
  always @(posedge leadEdge) begin
    if (!cpha) rxByte = {rxByte[6:0], mosi};
    else if (first) first = 1'b0;
    else shiftReg = {shiftReg[6:0], 1'b0};
  end
  always @(negedge leadEdge) begin
    if (cpha) rxByte = {rxByte[6:0], mosi};
    else shiftReg = {shiftReg[6:0], 1'b0};
  end
  // sole slave on the bus, answers without a select line
  assign miso = shiftReg[7];
endmodule
